// *** logic/pcs_params.svh ***
/*
 * Offsets, field positions, reset values and fold limits for the phase
 * compensation and power sign register block.
 * Assumes inclusion by bare name from the package and design modules.
 */
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// ----------------------------------------------------------------------
// Host port widths and register offsets
// ----------------------------------------------------------------------
`define PCS_ADDR_W 16
`define PCS_DATA_W 16
`define PCS_ADDR_COMP_A 16'hE614
`define PCS_ADDR_COMP_B 16'hE615
`define PCS_ADDR_COMP_C 16'hE616
`define PCS_ADDR_SIGN 16'hE617

// ----------------------------------------------------------------------
// Compensation register fields
// ----------------------------------------------------------------------
`define PCS_COMP_W 10
`define PCS_COMP_RST 10'h000
`define PCS_DELAY_W 9
`define PCS_FOLD_LOW 10'h180
`define PCS_FOLD_HIGH 10'h200
`define PCS_FOLD_SHIFT 10'h080
`define PCS_VOLT_MASK 10'h07F

// ----------------------------------------------------------------------
// Sign status register fields
// ----------------------------------------------------------------------
`define PCS_SIGN_W 9
`define PCS_SIGN_RST 9'h000
`define PCS_BIT_ACT0 0
`define PCS_BIT_REACT0 4
`define PCS_BIT_SUM1 3
`define PCS_BIT_SUM2 7
`define PCS_BIT_SUM3 8

// ----------------------------------------------------------------------
// Power sample widths and power type codes
// ----------------------------------------------------------------------
`define PCS_PWR_W 24
`define PCS_SUM_W 26
`define PCS_SEL_W 3
`define PCS_TYPE_ACTIVE 3'h0
`define PCS_TYPE_REACTIVE 3'h1
`define PCS_TYPE_APPARENT 3'h2

`endif

// *** logic/pcs_pkg.sv ***
/*
 * Types shared by the phase compensation and power sign modules.
 * Assumes pcs_params.svh is on the include path.
 */
`include "pcs_params.svh"

package pcs_pkg;

  // ----------------------------------------------------------------------
  // Power sample and power type
  // ----------------------------------------------------------------------
  typedef logic signed [`PCS_PWR_W-1:0] pcs_power_t;
  typedef logic [`PCS_SEL_W-1:0] pcs_sel_t;
  typedef enum logic [1:0] {
    PCS_ACTIVE,
    PCS_REACTIVE,
    PCS_APPARENT
  } pcs_kind_e;

  // Unknown codes fall back to active power
  function automatic pcs_kind_e pcs_decode_kind(input pcs_sel_t code);
    pcs_kind_e kind;
    kind = PCS_ACTIVE;
    if (code == `PCS_TYPE_REACTIVE) begin
      kind = PCS_REACTIVE;
    end else if (code == `PCS_TYPE_APPARENT) begin
      kind = PCS_APPARENT;
    end
    return kind;
  endfunction : pcs_decode_kind

endpackage : pcs_pkg

// *** logic/pcs_comp_fold.sv ***
/*
 * Folds one 10-bit phase compensation code into a delay and a channel.
 * Assumes a registered code on the same clock; output is combinational.
 */
`timescale 1ns/10ps
`include "pcs_params.svh"

module pcs_comp_fold
  import pcs_pkg::*;
(
  input wire logic [`PCS_COMP_W-1:0] compValue,
  output logic [`PCS_DELAY_W-1:0] delayCode,
  output logic onVoltage
);

  logic [`PCS_COMP_W-1:0] shifted;

  assign shifted = compValue - `PCS_FOLD_SHIFT;

  // ----------------------------------------------------------------------
  // Code folding
  // ----------------------------------------------------------------------
  always_comb begin
    if (compValue < `PCS_FOLD_LOW) begin
      delayCode = compValue[`PCS_DELAY_W-1:0];
      onVoltage = 1'b0;
    end else if (compValue < `PCS_FOLD_HIGH) begin
      delayCode = shifted[`PCS_DELAY_W-1:0];
      onVoltage = 1'b0;
    end else begin
      delayCode = {2'h0, compValue[6:0]};
      onVoltage = 1'b1;
    end
  end

endmodule : pcs_comp_fold

// *** logic/pcs_path_sum.sv ***
/*
 * Sums the chosen phase powers of one pulse-output path, gives the sign.
 * Assumes power samples on the same clock; output is combinational.
 */
`timescale 1ns/10ps
`include "pcs_params.svh"

module pcs_path_sum
  import pcs_pkg::*;
(
  input wire pcs_power_t [2:0] activePower,
  input wire pcs_power_t [2:0] reactivePower,
  input wire pcs_power_t [2:0] apparentPower,
  input wire pcs_sel_t phaseSelect,
  input wire pcs_sel_t powerType,
  output logic sumNeg
);

  logic signed [`PCS_SUM_W-1:0] total;
  pcs_kind_e kind;

  assign kind = pcs_decode_kind(powerType);

  // ----------------------------------------------------------------------
  // Signed sum of selected phases
  // ----------------------------------------------------------------------
  always_comb begin
    total = '0;
    for (int p = 0; p < 3; p++) begin
      if (phaseSelect[p]) begin
        unique case (kind)
          PCS_REACTIVE: total = total + `PCS_SUM_W'(reactivePower[p]);
          PCS_APPARENT: total = total + `PCS_SUM_W'(apparentPower[p]);
          PCS_ACTIVE: total = total + `PCS_SUM_W'(activePower[p]);
        endcase
      end
    end
  end

  assign sumNeg = total[`PCS_SUM_W-1];

endmodule : pcs_path_sum

// *** logic/pcs_regs.sv ***
/*
 * Phase compensation registers and power sign status register.
 * Assumes the host serial port decodes frames into one-cycle register
 * strobes on ref_clk, and the signal processor flags new power results.
 */
`timescale 1ns/10ps
`include "pcs_params.svh"

// Notes on behaviour
// - Compensation registers keep a 10-bit code, 0 to 383 delays current.
// - Codes 384 to 511 act like codes 256 to 383.
// - Codes 512 to 1023 delay by their low 7 bits, 0 to 127, on the voltage channel.
// - Bits 15 to 10 do nothing, and the register resets to zero.
// - Sign bits 0 to 2 show negative active power on phases A to C.
// - Sign bits 4 to 6 show negative reactive power on phases A to C.
// - Phase A reactive sign follows total or fundamental as selected.
// - Sign bit 3 shows the sign of the first pulse path sum.
// - Sign bit 7 shows the sign of the second pulse path sum.
// - Sign bit 8 shows the sign of the third pulse path sum.
// - Sign bits 15 to 9 read zero, and all sign flags reset to zero.
// - Power type codes 0, 1, 2 pick active, reactive, apparent, else active.
module pcs_regs
  import pcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [`PCS_ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [`PCS_DATA_W-1:0] regWrData,
  input wire logic regRdEn,
  output logic [`PCS_DATA_W-1:0] regRdData,
  output logic regRdValid,
  input wire logic powerValid,
  input wire pcs_power_t [2:0] activePower,
  input wire pcs_power_t [2:0] reactTotal,
  input wire pcs_power_t [2:0] reactFund,
  input wire pcs_power_t [2:0] apparentPower,
  input wire logic reverseReactiveSelect,
  input wire pcs_sel_t path1PhaseSelect,
  input wire pcs_sel_t path2PhaseSelect,
  input wire pcs_sel_t path3PhaseSelect,
  input wire pcs_sel_t path1PowerType,
  input wire pcs_sel_t path2PowerType,
  input wire pcs_sel_t path3PowerType,
  output logic [2:0][`PCS_DELAY_W-1:0] compDelay,
  output logic [2:0] compOnVoltage
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [2:0][`PCS_COMP_W-1:0] compQ;
  logic [2:0][`PCS_DELAY_W-1:0] foldDelay;
  logic [2:0][`PCS_DELAY_W-1:0] compDelay_q;
  logic [2:0] foldVoltage;
  logic [2:0] compOnVoltage_q;
  logic [`PCS_SIGN_W-1:0] signQ;
  logic [`PCS_SIGN_W-1:0] signD;
  logic [2:0] compHit;
  logic signHit;
  logic [`PCS_DATA_W-1:0] rdMux;
  logic [`PCS_DATA_W-1:0] regRdData_q;
  logic regRdValid_q;
  pcs_power_t [2:0] reactSel;
  pcs_sel_t [2:0] pathPhase;
  pcs_sel_t [2:0] pathType;
  logic [2:0] pathNeg;

  assign pathPhase = {path3PhaseSelect, path2PhaseSelect, path1PhaseSelect};
  assign pathType = {path3PowerType, path2PowerType, path1PowerType};
  assign signHit = (regAddr == `PCS_ADDR_SIGN);

  // ----------------------------------------------------------------------
  // Per-phase compensation registers and folding
  // ----------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_phase
      assign compHit[p] = (regAddr == `PCS_ADDR_COMP_A + `PCS_ADDR_W'(p));

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          compQ[p] <= `PCS_COMP_RST;
        end else if (regWrEn && compHit[p]) begin
          compQ[p] <= regWrData[`PCS_COMP_W-1:0];
        end
      end

      pcs_comp_fold u_fold (
        .compValue(compQ[p]),
        .delayCode(foldDelay[p]),
        .onVoltage(foldVoltage[p])
      );

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          compDelay_q[p] <= '0;
          compOnVoltage_q[p] <= 1'b0;
        end else begin
          compDelay_q[p] <= foldDelay[p];
          compOnVoltage_q[p] <= foldVoltage[p];
        end
      end

      if (p == 0) begin : g_react_a
        assign reactSel[p] = reverseReactiveSelect ?
                             reactFund[p] : reactTotal[p];
      end else begin : g_react_bc
        assign reactSel[p] = reactTotal[p];
      end

      assign signD[`PCS_BIT_ACT0 + p] =
        activePower[p][`PCS_PWR_W-1];
      assign signD[`PCS_BIT_REACT0 + p] =
        reactSel[p][`PCS_PWR_W-1];

      pcs_path_sum u_sum (
        .activePower(activePower),
        .reactivePower(reactTotal),
        .apparentPower(apparentPower),
        .phaseSelect(pathPhase[p]),
        .powerType(pathType[p]),
        .sumNeg(pathNeg[p])
      );
    end
  endgenerate

  assign compDelay = compDelay_q;
  assign compOnVoltage = compOnVoltage_q;

  // ----------------------------------------------------------------------
  // Sign status register
  // ----------------------------------------------------------------------
  assign signD[`PCS_BIT_SUM1] = pathNeg[0];
  assign signD[`PCS_BIT_SUM2] = pathNeg[1];
  assign signD[`PCS_BIT_SUM3] = pathNeg[2];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      signQ <= `PCS_SIGN_RST;
    end else if (powerValid) begin
      signQ <= signD;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    rdMux = '0;
    for (int i = 0; i < 3; i++) begin
      if (compHit[i]) begin
        rdMux = {6'h00, compQ[i]};
      end
    end
    if (signHit) begin
      rdMux = {7'h00, signQ};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regRdData_q <= '0;
    end else if (regRdEn) begin
      regRdData_q <= rdMux;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regRdValid_q <= 1'b0;
    end else begin
      regRdValid_q <= regRdEn;
    end
  end

  assign regRdData = regRdData_q;
  assign regRdValid = regRdValid_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_foldCurrent;
    @(posedge ref_clk) disable iff (!rst_n)
    (compQ[0] < 10'h180) |=>
      (compDelay_q[0] == $past(compQ[0][8:0])) && !compOnVoltage_q[0];
  endproperty
  a_foldCurrent: assert property (p_foldCurrent)
    else $error("current code not passed through");

  property p_foldMid;
    @(posedge ref_clk) disable iff (!rst_n)
    (compQ[1] >= 10'h180 && compQ[1] < 10'h200) |=>
      (compDelay_q[1] == 9'($past(compQ[1]) - 10'h080))
      && !compOnVoltage_q[1];
  endproperty
  a_foldMid: assert property (p_foldMid)
    else $error("codes 384 to 511 not folded by 128");

  property p_foldHigh;
    @(posedge ref_clk) disable iff (!rst_n)
    (compQ[2] >= 10'h200) |=>
      compOnVoltage_q[2] && (compDelay_q[2] == {2'h0, $past(compQ[2][6:0])});
  endproperty
  a_foldHigh: assert property (p_foldHigh)
    else $error("high code not folded to voltage channel");

  property p_compRead;
    @(posedge ref_clk) disable iff (!rst_n)
    (regRdEn && compHit[0]) |=>
      regRdValid && (regRdData == {6'h00, $past(compQ[0])});
  endproperty
  a_compRead: assert property (p_compRead)
    else $error("compensation read wrong or reserved bits set");

  property p_writeStore;
    @(posedge ref_clk) disable iff (!rst_n)
    (regWrEn && compHit[1]) |=> (compQ[1] == $past(regWrData[9:0]));
  endproperty
  a_writeStore: assert property (p_writeStore)
    else $error("compensation write not stored");

  property p_activeSign;
    @(posedge ref_clk) disable iff (!rst_n)
    powerValid |=> (signQ[2:0] == {$past(activePower[2][23]),
      $past(activePower[1][23]), $past(activePower[0][23])});
  endproperty
  a_activeSign: assert property (p_activeSign)
    else $error("active power sign flags wrong");

  property p_reactA;
    @(posedge ref_clk) disable iff (!rst_n)
    (powerValid && reverseReactiveSelect) |=>
      (signQ[4] == $past(reactFund[0][23]));
  endproperty
  a_reactA: assert property (p_reactA)
    else $error("phase A reactive sign not from fundamental");

  property p_reactBC;
    @(posedge ref_clk) disable iff (!rst_n)
    powerValid |=> (signQ[6:5] == {$past(reactTotal[2][23]),
      $past(reactTotal[1][23])});
  endproperty
  a_reactBC: assert property (p_reactBC)
    else $error("reactive sign flags wrong");

  property p_sum1Single;
    @(posedge ref_clk) disable iff (!rst_n)
    (powerValid && path1PhaseSelect == 3'h1 && path1PowerType == 3'h1)
      |=> (signQ[3] == $past(reactTotal[0][23]));
  endproperty
  a_sum1Single: assert property (p_sum1Single)
    else $error("path 1 sign wrong for single reactive phase");

  property p_sum2Fallback;
    @(posedge ref_clk) disable iff (!rst_n)
    (powerValid && path2PhaseSelect == 3'h2 && path2PowerType == 3'h5)
      |=> (signQ[7] == $past(activePower[1][23]));
  endproperty
  a_sum2Fallback: assert property (p_sum2Fallback)
    else $error("path 2 reserved type not treated as active");

  property p_sum3Empty;
    @(posedge ref_clk) disable iff (!rst_n)
    (powerValid && path3PhaseSelect == 3'h0) |=> !signQ[8];
  endproperty
  a_sum3Empty: assert property (p_sum3Empty)
    else $error("path 3 with no phases must read positive");

  property p_signHold;
    @(posedge ref_clk) disable iff (!rst_n)
    !powerValid |=> $stable(signQ);
  endproperty
  a_signHold: assert property (p_signHold)
    else $error("sign flags changed without new power result");

  property p_signRead;
    @(posedge ref_clk) disable iff (!rst_n)
    (regRdEn && signHit) |=> regRdValid && (regRdData[15:9] == 7'h00);
  endproperty
  a_signRead: assert property (p_signRead)
    else $error("sign register reserved bits not zero");

  property p_reactATotal;
    @(posedge ref_clk) disable iff (!rst_n)
    (powerValid && !reverseReactiveSelect) |=>
      (signQ[4] == $past(reactTotal[0][23]));
  endproperty
  a_reactATotal: assert property (p_reactATotal)
    else $error("phase A reactive sign not from total");

  property p_sum3Single;
    @(posedge ref_clk) disable iff (!rst_n)
    (powerValid && path3PhaseSelect == 3'h1 && path3PowerType == 3'h0)
      |=> (signQ[8] == $past(activePower[0][23]));
  endproperty
  a_sum3Single: assert property (p_sum3Single)
    else $error("path 3 sign wrong for single active phase");

  property p_signReadAll;
    @(posedge ref_clk) disable iff (!rst_n)
    (regRdEn && signHit) |=> (regRdData == {7'h00, $past(signQ)});
  endproperty
  a_signReadAll: assert property (p_signReadAll)
    else $error("sign register read does not return flags");

  property p_writeStoreA;
    @(posedge ref_clk) disable iff (!rst_n)
    (regWrEn && compHit[0]) |=> (compQ[0] == $past(regWrData[9:0]));
  endproperty
  a_writeStoreA: assert property (p_writeStoreA)
    else $error("phase A compensation write not stored");

endmodule : pcs_regs

// *** tb/tb_pcs_regs.sv ***
/*
 * Self-checking bench for the compensation and power sign registers.
 * Assumes the logic/ files compile first and pcs_params.svh is included.
 */
`timescale 1ns/10ps
`include "pcs_params.svh"

`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin \
  errorCnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end end

module tb_pcs_regs
  import pcs_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic regWrEn = 1'b0;
  logic [15:0] regWrData = 16'h0000;
  logic regRdEn = 1'b0;
  logic [15:0] regRdData;
  logic regRdValid;
  logic powerValid = 1'b0;
  pcs_power_t [2:0] activePower = '0;
  pcs_power_t [2:0] reactTotal = '0;
  pcs_power_t [2:0] reactFund = '0;
  pcs_power_t [2:0] apparentPower = '0;
  logic reverseReactiveSelect = 1'b0;
  pcs_sel_t path1PhaseSelect = 3'h7;
  pcs_sel_t path2PhaseSelect = 3'h2;
  pcs_sel_t path3PhaseSelect = 3'h1;
  pcs_sel_t path1PowerType = 3'h0;
  pcs_sel_t path2PowerType = 3'h0;
  pcs_sel_t path3PowerType = 3'h0;
  logic [2:0][8:0] compDelay;
  logic [2:0] compOnVoltage;
  int errorCnt = 0;
  int nTests = 0;
  int cycles = 0;
  int act[3] = '{-100, 50, 30};
  int rtot[3] = '{10, -20, 40};
  int rfun[3] = '{-7, 20, -40};
  int app[3] = '{1000, 2000, 3000};

  pcs_regs dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .powerValid(powerValid), .activePower(activePower),
    .reactTotal(reactTotal), .reactFund(reactFund),
    .apparentPower(apparentPower),
    .reverseReactiveSelect(reverseReactiveSelect),
    .path1PhaseSelect(path1PhaseSelect),
    .path2PhaseSelect(path2PhaseSelect),
    .path3PhaseSelect(path3PhaseSelect),
    .path1PowerType(path1PowerType), .path2PowerType(path2PowerType),
    .path3PowerType(path3PowerType), .compDelay(compDelay),
    .compOnVoltage(compOnVoltage)
  );

  // ----------------------------------------------------------------------
  // Clock, timeout, verdict
  // ----------------------------------------------------------------------
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errorCnt++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------------
  task automatic writeReg(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge ref_clk);
    regWrEn = 1'b0;
  endtask : writeReg

  task automatic readReg(input logic [15:0] a, input logic [15:0] expd);
    int k;
    @(negedge ref_clk);
    regAddr = a;
    regRdEn = 1'b1;
    for (k = 0; k < 3; k++) begin
      @(negedge ref_clk);
      regRdEn = 1'b0;
      if (regRdValid === 1'b1) break;
    end
    `CHK(regRdValid, 1'b1)
    `CHK(regRdData, expd)
    @(negedge ref_clk);
    `CHK(regRdValid, 1'b0)
  endtask : readReg

  // ----------------------------------------------------------------------
  // Power results and expected sign word
  // ----------------------------------------------------------------------
  function automatic logic pathNeg(int s, pcs_sel_t sel, pcs_sel_t t);
    int sum;
    sum = 0;
    for (int i = 0; i < 3; i++) begin
      if (sel[i]) begin
        sum += s * ((t == 3'h1) ? rtot[i] : (t == 3'h2) ? app[i] : act[i]);
      end
    end
    return sum < 0;
  endfunction : pathNeg

  function automatic logic [15:0] expSign(int s, logic rev, pcs_sel_t t);
    logic [15:0] w;
    w = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      w[i] = (s * act[i]) < 0;
      w[4 + i] = (s * rtot[i]) < 0;
    end
    w[4] = (s * (rev ? rfun[0] : rtot[0])) < 0;
    w[3] = pathNeg(s, path1PhaseSelect, t);
    w[7] = pathNeg(s, path2PhaseSelect, t);
    w[8] = pathNeg(s, path3PhaseSelect, t);
    return w;
  endfunction : expSign

  task automatic applyPower(input int s, input logic rev, input pcs_sel_t t);
    @(negedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      activePower[i] = 24'(s * act[i]);
      reactTotal[i] = 24'(s * rtot[i]);
      reactFund[i] = 24'(s * rfun[i]);
      apparentPower[i] = 24'(s * app[i]);
    end
    reverseReactiveSelect = rev;
    path1PowerType = t;
    path2PowerType = t;
    path3PowerType = t;
    powerValid = 1'b1;
    @(negedge ref_clk);
    powerValid = 1'b0;
  endtask : applyPower

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic testResetValues;
    `CHK(compDelay, 27'h0000000)
    `CHK(compOnVoltage, 3'h0)
    `CHK(regRdValid, 1'b0)
    readReg(`PCS_ADDR_COMP_A, 16'h0000);
    readReg(`PCS_ADDR_COMP_B, 16'h0000);
    readReg(`PCS_ADDR_COMP_C, 16'h0000);
    readReg(`PCS_ADDR_SIGN, 16'h0000);
    writeReg(16'hE618, 16'h1234);
    readReg(16'hE618, 16'h0000);
  endtask : testResetValues

  task automatic testCompFold;
    int codes[9] = '{0, 1, 255, 383, 384, 511, 512, 575, 1023};
    int c;
    for (int p = 0; p < 3; p++) begin
      foreach (codes[j]) begin
        c = codes[j];
        writeReg(`PCS_ADDR_COMP_A + 16'(p), {6'h2B, 10'(c)});
        readReg(`PCS_ADDR_COMP_A + 16'(p), {6'h00, 10'(c)});
        @(negedge ref_clk);
        if (c < 384) begin
          `CHK(compDelay[p], 9'(c))
          `CHK(compOnVoltage[p], 1'b0)
        end else if (c < 512) begin
          `CHK(compDelay[p], 9'(c - 128))
          `CHK(compOnVoltage[p], 1'b0)
        end else begin
          `CHK(compDelay[p], 9'(c % 128))
          `CHK(compOnVoltage[p], 1'b1)
          if (c <= 575) begin
            `CHK(compDelay[p], 9'(c - 512))
          end
        end
      end
    end
    `CHK(compDelay[0], 9'h07F)
  endtask : testCompFold

  task automatic testSignFlags;
    for (int s = -1; s <= 1; s += 2) begin
      for (int r = 0; r < 2; r++) begin
        applyPower(s, r[0], 3'h0);
        readReg(`PCS_ADDR_SIGN, expSign(s, r[0], 3'h0));
      end
    end
  endtask : testSignFlags

  task automatic testPathTypes;
    for (int t = 0; t < 8; t++) begin
      applyPower(1, 1'b0, 3'(t));
      readReg(`PCS_ADDR_SIGN, expSign(1, 1'b0, 3'(t)));
    end
    path1PhaseSelect = 3'h0;
    applyPower(-1, 1'b0, 3'h1);
    readReg(`PCS_ADDR_SIGN, expSign(-1, 1'b0, 3'h1));
    path1PhaseSelect = 3'h1;
    path3PhaseSelect = 3'h0;
    applyPower(-1, 1'b0, 3'h1);
    readReg(`PCS_ADDR_SIGN, expSign(-1, 1'b0, 3'h1));
    path1PhaseSelect = 3'h7;
    path3PhaseSelect = 3'h1;
  endtask : testPathTypes

  task automatic testSignReadOnly;
    logic [15:0] held;
    applyPower(-1, 1'b1, 3'h2);
    held = expSign(-1, 1'b1, 3'h2);
    @(negedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      activePower[i] = 24'(act[i]);
      reactTotal[i] = 24'(rtot[i]);
    end
    writeReg(`PCS_ADDR_SIGN, 16'hFFFF);
    readReg(`PCS_ADDR_SIGN, held);
    readReg(`PCS_ADDR_COMP_A, {6'h00, 10'h3FF});
  endtask : testSignReadOnly

  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    testResetValues();
    testCompFold();
    testSignFlags();
    testPathTypes();
    testSignReadOnly();
    conclude();
  end

endmodule : tb_pcs_regs
